// *** rtl/msgbuf_pkg.sv ***
package msgbuf_pkg;
	// Number of message buffers tracked.
	localparam int NUM_BUF = 32;
	// Register offsets as word indexes on the shared interface.
	localparam logic [4:0] REG_FULL_LOW   = 5'h00;
	localparam logic [4:0] REG_FULL_HIGH  = 5'h01;
	localparam logic [4:0] REG_OVF_LOW    = 5'h02;
	localparam logic [4:0] REG_OVF_HIGH   = 5'h03;
	localparam logic [4:0] REG_PAIR_BASE  = 5'h04;
	localparam logic [4:0] REG_PAIR_LAST  = 5'h13;
	// AHB-Lite byte offsets of the controller's own registers.
	localparam logic [7:0] CMD_ADDR_OFF   = 8'h00;
	localparam logic [7:0] CMD_WDATA_OFF  = 8'h04;
	localparam logic [7:0] CMD_GO_OFF     = 8'h08;
	localparam logic [7:0] CMD_STAT_OFF   = 8'h0C;
	localparam logic [7:0] CMD_RDATA_OFF  = 8'h10;
	// Field positions inside one control byte.
	localparam int F_DIR   = 7;
	localparam int F_ABT   = 6;
	localparam int F_LARB  = 5;
	localparam int F_TERR  = 4;
	localparam int F_REQ   = 3;
	localparam int F_ARE   = 2;
	localparam int F_PRI_H = 1;
	localparam int F_PRI_L = 0;
	// Writable bits of a control byte; status bits are read only.
	localparam logic [7:0] CTRL_WMASK = 8'h8F;
	localparam logic [15:0] RESET_VAL = 16'h0000;
	// Buffer word layouts in system RAM.
	localparam int SID_MSB = 12;
	localparam int SID_LSB = 2;
	localparam int SRR_BIT = 1;
	localparam int IDE_BIT = 0;
	localparam int EIDH_MSB = 11;
	localparam int EIDL_MSB = 15;
	localparam int EIDL_LSB = 10;
	localparam int RTR_BIT = 9;
	localparam int RSV_HI_BIT = 8;
	localparam int RSV_LO_BIT = 4;
	localparam int DLC_MSB = 3;
	localparam int HIT_MSB = 12;
	localparam int HIT_LSB = 8;
	localparam logic [15:0] SID_WORD_MASK = 16'h1FFF;
	localparam logic [15:0] EID_WORD_MASK = 16'h0FFF;
	localparam logic [15:0] LEN_WORD_MASK = 16'hFF1F;
	localparam logic [15:0] STAT_WORD_MASK = 16'h1F00;
endpackage

// *** rtl/msgbuf_if.sv ***
`timescale 1ns/1ps
interface msgbuf_if;
	logic        wr;      // One-cycle register write strobe.
	logic        rd;      // One-cycle register read strobe.
	logic [4:0]  idx;     // Register word index.
	logic [15:0] wdata;   // Write data.
	logic [15:0] rdata;   // Read data, valid the cycle after rd.
	logic        rvalid;  // Read data valid pulse.
	modport dev (input wr, rd, idx, wdata, output rdata, rvalid);
	modport ctl (output wr, rd, idx, wdata, input rdata, rvalid);
endinterface

// *** rtl/msgbuf_ctl.sv ***
`timescale 1ns/1ps
module msgbuf_ctl
	import msgbuf_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	msgbuf_if.ctl            bus
);
	// Captured AHB address phase.
	logic        ph_wr_ff;
	logic        ph_act_ff;
	logic [7:0]  ph_addr_ff;
	logic [4:0]  addr_ff;     // Target register index.
	logic [15:0] wdat_ff;     // Data for a write command.
	logic        busy_ff;     // Command in flight.
	logic        done_ff;     // Last command finished.
	logic [15:0] rdat_ff;     // Last read result.
	logic        bwr_ff;
	logic        brd_ff;
	logic [31:0] hrdata_ff;

	// Register the address phase; every transfer answers in one wait-free cycle.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ph_act_ff  <= 1'b0;
			ph_wr_ff   <= 1'b0;
			ph_addr_ff <= 8'h00;
		end else if (i_ce) begin
			ph_act_ff  <= i_hsel & i_hready & i_htrans[1];
			ph_wr_ff   <= i_hwrite;
			ph_addr_ff <= i_haddr[7:0];
		end
	end

	// Command registers and device-side strobes.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_ff <= 5'h00;
			wdat_ff <= 16'h0000;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			rdat_ff <= 16'h0000;
			bwr_ff  <= 1'b0;
			brd_ff  <= 1'b0;
		end else if (i_ce) begin
			bwr_ff <= 1'b0;
			brd_ff <= 1'b0;
			if (ph_act_ff && ph_wr_ff) begin
				unique case (ph_addr_ff)
					CMD_ADDR_OFF:  addr_ff <= i_hwdata[4:0];
					CMD_WDATA_OFF: wdat_ff <= i_hwdata[15:0];
					CMD_GO_OFF: begin
						// Bit 0 selects write, otherwise a read is issued.
						bwr_ff  <= i_hwdata[0];
						brd_ff  <= ~i_hwdata[0];
						busy_ff <= 1'b1;
						done_ff <= 1'b0;
					end
					default: ;
				endcase
			end
			if (busy_ff && (bwr_ff || bus.rvalid)) begin
				busy_ff <= 1'b0;
				done_ff <= 1'b1;
			end
			if (bus.rvalid) begin
				rdat_ff <= bus.rdata;
			end
		end
	end

	// Read mux for the AHB data phase.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (i_ce && i_hsel && i_hready && i_htrans[1] && !i_hwrite) begin
			unique case (i_haddr[7:0])
				CMD_ADDR_OFF:  hrdata_ff <= {27'h000_0000, addr_ff};
				CMD_WDATA_OFF: hrdata_ff <= {16'h0000, wdat_ff};
				CMD_STAT_OFF:  hrdata_ff <= {30'h0000_0000, done_ff, busy_ff};
				CMD_RDATA_OFF: hrdata_ff <= {16'h0000, rdat_ff};
				default:       hrdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign o_hrdata    = hrdata_ff;
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;
	assign bus.wr      = bwr_ff;
	assign bus.rd      = brd_ff;
	assign bus.idx     = addr_ff;
	assign bus.wdata   = wdat_ff;
endmodule // msgbuf_ctl

// *** rtl/msgbuf_dev.sv ***
`timescale 1ns/1ps
module msgbuf_dev
	import msgbuf_pkg::*;
#(
	parameter int NB = NUM_BUF
)(
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	msgbuf_if.dev            bus,
	input  wire logic        i_rx_store,      // Receive message stored pulse.
	input  wire logic [4:0]  i_rx_buf,        // Buffer targeted by the store.
	input  wire logic [4:0]  i_rx_filter,     // Filter that matched.
	input  wire logic        i_remote_rx,     // Matching remote frame pulse.
	input  wire logic [4:0]  i_remote_buf,    // Buffer matched by remote frame.
	input  wire logic        i_tx_ok,         // Transmission success pulse.
	input  wire logic        i_tx_abort_done, // Abort completed pulse.
	input  wire logic        i_tx_lost_arb,   // Lost arbitration pulse.
	input  wire logic        i_tx_error,      // Bus error pulse.
	input  wire logic [4:0]  i_tx_buf,        // Buffer of the transmit event.
	output logic             o_ram_we,        // RAM status-word write strobe.
	output logic      [4:0]  o_ram_buf,       // Buffer of the RAM write.
	output logic      [15:0] o_ram_status,    // Status word with filter hit.
	output logic             o_tx_valid,      // A send is pending.
	output logic      [4:0]  o_tx_sel,        // Highest-priority pending buffer.
	output logic      [NB-1:0] o_abort_req    // Pending abort per buffer.
);
	logic [NB-1:0] full_ff, ovf_ff, dir_ff, abt_ff, larb_ff, terr_ff;
	logic [NB-1:0] req_ff, are_ff, abort_ff;
	logic [1:0]    pri_ff [NB];
	logic [15:0]   rdata_ff;
	logic          rvalid_ff;
	logic          ram_we_ff;
	logic [4:0]    ram_buf_ff;
	logic [15:0]   ram_stat_ff;
	logic          txv_ff;
	logic [4:0]    txs_ff;
	logic          nxt_txv;
	logic [4:0]    nxt_txs;
	logic [1:0]    best_pri;

	// Receive flags; set beats a software clear in the same cycle.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			full_ff <= '0;
			ovf_ff  <= '0;
		end else if (i_ce) begin
			logic [NB-1:0] fnxt, onxt;
			fnxt = full_ff;
			onxt = ovf_ff;
			if (bus.wr) begin
				// Only zeros clear; ones leave flags unchanged.
				unique case (bus.idx)
					REG_FULL_LOW:  fnxt[15:0]  = full_ff[15:0] & bus.wdata;
					REG_FULL_HIGH: fnxt[31:16] = full_ff[31:16] & bus.wdata;
					REG_OVF_LOW:   onxt[15:0]  = ovf_ff[15:0] & bus.wdata;
					REG_OVF_HIGH:  onxt[31:16] = ovf_ff[31:16] & bus.wdata;
					default: ;
				endcase
			end
			if (i_rx_store) begin
				if (full_ff[i_rx_buf]) begin
					onxt[i_rx_buf] = 1'b1;
				end
				fnxt[i_rx_buf] = 1'b1;
			end
			full_ff <= fnxt;
			ovf_ff  <= onxt;
		end
	end

	// Per-buffer control bits from the pair registers and transmit events.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dir_ff <= '0; abt_ff <= '0; larb_ff <= '0; terr_ff <= '0;
			req_ff <= '0; are_ff <= '0; abort_ff <= '0;
			for (int b = 0; b < NB; b++) pri_ff[b] <= 2'b00;
		end else if (i_ce) begin
			for (int b = 0; b < NB; b++) begin
				logic [7:0] wb;
				logic       hit;
				logic       set_req;
				// Odd buffer in the upper byte, even in the lower.
				wb  = b[0] ? bus.wdata[15:8] : bus.wdata[7:0];
				hit = bus.wr && (bus.idx == REG_PAIR_BASE + 5'(b >> 1));
				set_req = 1'b0;
				if (hit) begin
					dir_ff[b] <= wb[F_DIR];
					are_ff[b] <= wb[F_ARE];
					pri_ff[b] <= wb[F_PRI_H:F_PRI_L];
					if (wb[F_REQ]) begin
						set_req = ~req_ff[b];
					end else if (req_ff[b]) begin
						abort_ff[b] <= 1'b1;
					end
				end
				if (i_remote_rx && i_remote_buf == 5'(b) && are_ff[b]) begin
					set_req = 1'b1;
				end
				if (set_req) begin
					req_ff[b]  <= 1'b1;
					abort_ff[b] <= 1'b0;
					abt_ff[b]  <= 1'b0;
					larb_ff[b] <= 1'b0;
					terr_ff[b] <= 1'b0;
				end else if (i_tx_buf == 5'(b)) begin
					if (i_tx_ok) begin
						req_ff[b]   <= 1'b0;
						abt_ff[b]   <= 1'b0;
						abort_ff[b] <= 1'b0;
					end
					if (i_tx_abort_done) begin
						req_ff[b]   <= 1'b0;
						abt_ff[b]   <= 1'b1;
						abort_ff[b] <= 1'b0;
					end
					if (i_tx_lost_arb) larb_ff[b] <= 1'b1;
					if (i_tx_error)    terr_ff[b] <= 1'b1;
				end
			end
		end
	end

	// Priority pick: highest field wins, lowest index breaks ties.
	always_comb begin
		nxt_txv  = 1'b0;
		nxt_txs  = 5'h00;
		best_pri = 2'b00;
		for (int b = 0; b < NB; b++) begin
			if (req_ff[b] && dir_ff[b] && (!nxt_txv || pri_ff[b] > best_pri)) begin
				nxt_txv  = 1'b1;
				nxt_txs  = 5'(b);
				best_pri = pri_ff[b];
			end
		end
	end

	// Register read port, data valid one cycle after the strobe.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_ff  <= RESET_VAL;
			rvalid_ff <= 1'b0;
			txv_ff    <= 1'b0;
			txs_ff    <= 5'h00;
		end else if (i_ce) begin
			rvalid_ff <= bus.rd;
			txv_ff    <= nxt_txv;
			txs_ff    <= nxt_txs;
			if (bus.rd) begin
				unique case (bus.idx)
					REG_FULL_LOW:  rdata_ff <= full_ff[15:0];
					REG_FULL_HIGH: rdata_ff <= full_ff[31:16];
					REG_OVF_LOW:   rdata_ff <= ovf_ff[15:0];
					REG_OVF_HIGH:  rdata_ff <= ovf_ff[31:16];
					default: begin
						if (bus.idx >= REG_PAIR_BASE && bus.idx <= REG_PAIR_LAST) begin
							logic [4:0] e;
							e = 5'((bus.idx - REG_PAIR_BASE) << 1);
							rdata_ff <= {dir_ff[e+1], abt_ff[e+1], larb_ff[e+1],
								terr_ff[e+1], req_ff[e+1], are_ff[e+1], pri_ff[e+1],
								dir_ff[e], abt_ff[e], larb_ff[e], terr_ff[e],
								req_ff[e], are_ff[e], pri_ff[e]};
						end else begin
							rdata_ff <= RESET_VAL;
						end
					end
				endcase
			end
		end
	end

	// Receive-status word write to shared RAM with the filter hit code.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ram_we_ff   <= 1'b0;
			ram_buf_ff  <= 5'h00;
			ram_stat_ff <= 16'h0000;
		end else if (i_ce) begin
			ram_we_ff <= i_rx_store;
			if (i_rx_store) begin
				ram_buf_ff  <= i_rx_buf;
				ram_stat_ff <= {3'b000, i_rx_filter, 8'h00};
			end
		end
	end

	assign bus.rdata    = rdata_ff;
	assign bus.rvalid   = rvalid_ff;
	assign o_ram_we     = ram_we_ff;
	assign o_ram_buf    = ram_buf_ff;
	assign o_ram_status = ram_stat_ff;
	assign o_tx_valid   = txv_ff;
	assign o_tx_sel     = txs_ff;
	assign o_abort_req  = abort_ff;
endmodule // msgbuf_dev

// *** tb/msgbuf_monitor.sv ***
`timescale 1ns/1ps
module msgbuf_monitor
	import msgbuf_pkg::*;
(
	input wire logic        i_core_clk,
	input wire logic        i_rst_n,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [4:0]  i_idx,
	input wire logic [15:0] i_wdata,
	input wire logic [15:0] i_rdata,
	input wire logic        i_rvalid
);
	logic      [15:0] cfg_ff [16];                    // Software-owned bits per pair.
	logic      [4:0]  ridx_ff;                        // Index of the last read.
	wire logic [4:0]  woff = i_idx - REG_PAIR_BASE;   // Pair slot of a write.
	wire logic [4:0]  roff = ridx_ff - REG_PAIR_BASE; // Pair slot of a read.
	// Shadow the bits that only software changes, so reads can be judged.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int k = 0; k < 16; k++) cfg_ff[k] <= 16'h0000;
		end else if (i_wr && woff < 5'h10) begin
			cfg_ff[woff[3:0]] <= i_wdata & 16'h8787;
		end
	end
	// Remember which register the read in flight targets.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ridx_ff <= 5'h00;
		end else if (i_rd) begin
			ridx_ff <= i_idx;
		end
	end
	default clocking mon_cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	a_read_gets_data: assert property (i_rd |=> i_rvalid) else $error("read not answered");
	a_data_has_cause: assert property (i_rvalid |-> $past(i_rd)) else $error("stray data");
	a_one_access_only: assert property (!(i_rd && i_wr)) else $error("read with write");
	a_write_one_cycle: assert property (i_wr |=> !i_wr) else $error("write too long");
	a_read_one_cycle: assert property (i_rd |=> !i_rd) else $error("read too long");
	a_answer_one_cycle: assert property (i_rvalid |=> !i_rvalid) else $error("data twice");
	a_reset_quiet_link: assert property (@(posedge i_core_clk) disable iff (1'b0)
		!i_rst_n |-> !i_rvalid && !i_wr && !i_rd) else $error("link busy in reset");
	a_pair_config_kept: assert property (i_rvalid && roff < 5'h10 |->
		(i_rdata & 16'h8787) == cfg_ff[roff[3:0]]) else $error("pair config lost");
endmodule // msgbuf_monitor

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
	import msgbuf_pkg::*;
	logic        i_core_clk, i_rst_n, hsel, hwrite, hreadyout, hresp;
	logic        ce;      // Clock enable shared by both ends.
	logic [31:0] haddr, hwdata, hrdata, abort_req;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        rx_store, remote_rx, tx_ok, tx_abt, tx_larb, tx_err, ram_we, tx_valid;
	logic [4:0]  rx_buf, rx_filter, remote_buf, tx_buf, ram_buf, tx_sel;
	logic [15:0] ram_status;
	logic [63:0] fl;      // Expected full flags, then overflow flags.
	logic [7:0]  cb [32]; // Expected control byte of each buffer.
	int          seed = 6234;
	int          err_total = 0;
	int          samples_checked = 0;
	msgbuf_if u_msgbuf_if ();
	msgbuf_ctl u_msgbuf_ctl (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(ce),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp), .bus(u_msgbuf_if));
	msgbuf_dev u_msgbuf_dev (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(ce),
		.bus(u_msgbuf_if), .i_rx_store(rx_store), .i_rx_buf(rx_buf), .i_rx_filter(rx_filter),
		.i_remote_rx(remote_rx), .i_remote_buf(remote_buf), .i_tx_ok(tx_ok),
		.i_tx_abort_done(tx_abt), .i_tx_lost_arb(tx_larb), .i_tx_error(tx_err),
		.i_tx_buf(tx_buf), .o_ram_we(ram_we), .o_ram_buf(ram_buf), .o_ram_status(ram_status),
		.o_tx_valid(tx_valid), .o_tx_sel(tx_sel), .o_abort_req(abort_req));
	msgbuf_monitor u_msgbuf_monitor (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_wr(u_msgbuf_if.wr), .i_rd(u_msgbuf_if.rd), .i_idx(u_msgbuf_if.idx),
		.i_wdata(u_msgbuf_if.wdata), .i_rdata(u_msgbuf_if.rdata),
		.i_rvalid(u_msgbuf_if.rvalid));
	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// One single AHB transfer; entered just after a rising edge.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge i_core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge i_core_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	// Device register access through the controller, polling done.
	task automatic dacc(input logic w, input logic [4:0] i, input logic [15:0] d,
		output logic [15:0] q);
		logic [31:0] r;
		int          n;
		ahb(1'b1, CMD_ADDR_OFF, {27'h000_0000, i}, r);
		ahb(1'b1, CMD_WDATA_OFF, {16'h0000, d}, r);
		ahb(1'b1, CMD_GO_OFF, {31'h0000_0000, w}, r);
		n = 0;
		do begin
			ahb(1'b0, CMD_STAT_OFF, 32'h0000_0000, r);
			n++;
		end while (r[1] !== 1'b1 && n < 40);
		ahb(1'b0, CMD_RDATA_OFF, 32'h0000_0000, r);
		q = r[15:0];
	endtask
	// Highest priority pending transmit buffer, lowest index on ties.
	function automatic logic [5:0] pick();
		logic [5:0] r;
		int         best;
		r = 6'h00;
		best = -1;
		for (int b = 0; b < 32; b++) begin
			if (cb[b][7] && cb[b][3] && int'(cb[b][1:0]) > best) begin
				best = int'(cb[b][1:0]);
				r = {1'b1, b[4:0]};
			end
		end
		return r;
	endfunction
	task automatic pchk(input logic [4:0] b);
		logic [15:0] q;
		dacc(1'b0, REG_PAIR_BASE + 5'(b[4:1]), 16'h0000, q);
		chk(q, {cb[{b[4:1], 1'b1}], cb[{b[4:1], 1'b0}]});
		chk({tx_valid, tx_sel}, pick());
	endtask
	task automatic pwr(input logic [3:0] k, input logic [15:0] d);
		logic [15:0] q;
		logic [7:0]  c;
		logic [7:0]  n;
		dacc(1'b1, REG_PAIR_BASE + 5'(k), d, q);
		for (int h = 0; h < 2; h++) begin
			c = cb[{k, h[0]}];
			n = d[h*8 +: 8];
			cb[{k, h[0]}] = {n[7], (n[3] & !c[3]) ? 3'b000 : c[6:4], n[3], n[2:0]};
		end
	endtask
	task automatic chk_all();
		logic [15:0] q;
		for (int i = 0; i < 20; i++) begin
			dacc(1'b0, 5'(i), 16'h0000, q);
			if (i < 4) chk(q, fl[i*16 +: 16]);
			else chk(q, {cb[2*i-7], cb[2*i-8]});
		end
	endtask
	task automatic store(input logic [4:0] b, input logic [4:0] f);
		rx_buf <= b;
		rx_filter <= f;
		rx_store <= 1'b1;
		@(posedge i_core_clk);
		rx_store <= 1'b0;
		fl[32+b] = fl[32+b] | fl[b];
		fl[b] = 1'b1;
		// The strobe stands for the cycle after the store edge; look once it has settled.
		#1;
		for (int n = 0; n < 4 && ram_we !== 1'b1; n++) @(posedge i_core_clk) #1;
		chk({ram_we, ram_buf, ram_status}, {1'b1, b, 3'b000, f, 8'h00});
		@(posedge i_core_clk);
	endtask
	// Pulse {ok, abort done, lost arbitration, error, remote} for one buffer.
	task automatic ev(input logic [4:0] m, input logic [4:0] b);
		{tx_ok, tx_abt, tx_larb, tx_err, remote_rx} <= m;
		tx_buf <= b;
		remote_buf <= b;
		@(posedge i_core_clk);
		{tx_ok, tx_abt, tx_larb, tx_err, remote_rx} <= 5'h00;
		@(posedge i_core_clk);
	endtask
	initial begin
		repeat (20000) @(posedge i_core_clk);
		err_total++;
		final_report();
	end
	initial begin
		logic [15:0] q;
		logic [31:0] r;
		logic [5:0]  p;
		logic [4:0]  m;
		// Wait a moment so the reset edge reaches flip-flops already waiting for it.
		#1;
		{i_rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		ce = 1'b1;
		{rx_store, remote_rx, tx_ok, tx_abt, tx_larb, tx_err} = '0;
		{rx_buf, rx_filter, remote_buf, tx_buf} = '0;
		fl = '0;
		foreach (cb[b]) cb[b] = 8'h00;
		repeat (4) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		chk_all();
		ahb(1'b0, 8'h40, 32'h0000_0000, r);
		chk(r, 32'h0000_0000);
		chk(hresp, 32'h0000_0000);
		chk({SID_WORD_MASK, EID_WORD_MASK}, 32'h1FFF_0FFF);
		chk({LEN_WORD_MASK, STAT_WORD_MASK}, 32'hFF1F_1F00);
		chk({8'(SID_MSB), 8'(SID_LSB), 8'(SRR_BIT), 8'(IDE_BIT)}, 32'h0C02_0100);
		chk({8'(EIDH_MSB), 8'(EIDL_MSB), 8'(EIDL_LSB), 8'(RTR_BIT)}, 32'h0B0F_0A09);
		chk({8'(RSV_HI_BIT), 8'(RSV_LO_BIT), 8'(DLC_MSB), 8'(HIT_MSB)}, 32'h0804_030C);
		$display("test reset done");
		store(5'd0, 5'd31);
		store(5'd0, 5'd1);
		store(5'd31, 5'd0);
		repeat (10) store(5'($random(seed)), 5'($random(seed)));
		chk_all();
		$display("test receive done");
		dacc(1'b1, REG_FULL_LOW, 16'hFFFF, q);
		for (int i = 1; i < 4; i++) begin
			q = 16'($random(seed));
			fl[i*16 +: 16] = fl[i*16 +: 16] & q;
			dacc(1'b1, 5'(i), q, q);
		end
		chk_all();
		$display("test clear done");
		pwr(4'd0, 16'h8480);
		ev(5'b00001, 5'd1);
		ev(5'b00001, 5'd0);
		cb[1] = 8'h8C;
		pchk(5'd1);
		$display("test remote done");
		for (int k = 0; k < 16; k++) begin
			q = 16'($random(seed)) & 16'h8F8F;
			pwr(4'(k), q | ((k == 0) ? 16'h8800 : (k == 15) ? 16'h8B00 : 16'h0000));
			pchk({4'(k), 1'b0});
		end
		for (int i = 0; i < 6; i++) begin
			p = pick();
			m = (i % 3 == 0) ? 5'b10000 : (i % 3 == 1) ? 5'b00100 : 5'b00010;
			if (p[5]) begin
				ev(m, p[4:0]);
				cb[p[4:0]] = (cb[p[4:0]] & ~{4'h0, m[4], 3'b000}) | {2'b00, m[2], m[1], 4'h0};
				pchk(p[4:0]);
			end
		end
		$display("test transmit done");
		p = pick();
		if (p[5]) begin
			q = {cb[{p[4:1], 1'b1}], cb[{p[4:1], 1'b0}]};
			pwr(p[4:1], q & ~(16'h0008 << (8 * p[0])));
			chk(abort_req[p[4:0]], 1'b1);
			ev(5'b01000, p[4:0]);
			chk(abort_req[p[4:0]], 1'b0);
			cb[p[4:0]][6] = 1'b1;
			pchk(p[4:0]);
			pwr(p[4:1], q);
			pchk(p[4:0]);
		end
		$display("test abort done");
		// Empty the low full flags, then offer a store while the enable is low.
		dacc(1'b1, REG_FULL_LOW, 16'h0000, q);
		fl[15:0] = 16'h0000;
		ce <= 1'b0;
		rx_buf <= 5'd2;
		rx_store <= 1'b1;
		@(posedge i_core_clk);
		ce <= 1'b1;
		rx_store <= 1'b0;
		@(posedge i_core_clk);
		chk_all();
		$display("test enable done");
		// Reset in mid-run must bring every flag and control bit back to zero.
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		fl = '0;
		foreach (cb[b]) cb[b] = 8'h00;
		chk_all();
		chk(abort_req, 32'h0000_0000);
		$display("test reset again done");
		final_report();
	end
endmodule // tb
